// file: hdl/vcs_defines.vh
`ifndef VCS_DEFINES_VH
`define VCS_DEFINES_VH
// ==========================================
// Register map (byte offsets)
`define VCS_ADR_MODE 8'h00
`define VCS_ADR_SCALE 8'h04
`define VCS_ADR_BUF 8'h08
`define VCS_ADR_HLIM 8'h0c
`define VCS_ADR_STAT 8'h10
// ==========================================
// Field positions of capture_mode_setting
`define VCS_MODE_SCL 1:0
`define VCS_MODE_VI 2
`define VCS_MODE_NATIVE_RGB_SELECT 3
`define VCS_MODE_HY 5:4
`define VCS_MODE_HC 7:6
`define VCS_MODE_VY 9:8
`define VCS_MODE_VC 11:10
`define VCS_SCL_REDUCE 2'h3
// Field positions of capture_buffer_setup
`define VCS_BUF_ODD 0
`define VCS_BUF_555 1
// ==========================================
// Reset values and fixed-point constants
`define VCS_MODE_RST 12'h000
`define VCS_SCALE_RST 32'h08000800
`define VCS_BUF_RST 2'h0
`define VCS_HLIM_RST 10'h348
`define VCS_ONE 18'h00800
`endif

// file: hdl/vcs_video_capture_scaler.v
// The address map and register access over Wishbone were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "vcs_defines.vh"

module vcs_video_capture_scaler (
    input wire clk_i,               // System clock
    input wire rst_i,               // Synchronous reset, active high
    input wire wb_cyc_i,            // Wishbone cycle
    input wire wb_stb_i,            // Wishbone strobe
    input wire wb_we_i,             // Wishbone write enable
    input wire [7:0] wb_adr_i,      // Wishbone byte address
    input wire [3:0] wb_sel_i,      // Wishbone byte selects
    input wire [31:0] wb_dat_i,     // Wishbone write data
    output reg [31:0] wb_dat_o,     // Wishbone read data
    output reg wb_ack_o,            // Wishbone acknowledge
    input wire cap_valid_i,         // Captured pixel valid
    input wire cap_sol_i,           // First pixel of a line
    input wire cap_sof_i,           // First pixel of a field
    input wire cap_field_i,         // Field of pixel, 1 = odd
    input wire [23:0] cap_data_i,   // Pixel {c2,c1,c0}, c0 luma
    input wire rd_valid_i,          // Frame-memory read pixel valid
    input wire rd_sol_i,            // Read pixel starts a line
    input wire rd_sof_i,            // Read pixel starts a frame
    input wire [23:0] rd_data_i,    // Read pixel data
    output reg rd_ready_o,          // Read pixel accepted when high
    output reg rd_new_line_o,       // Next read line is fresh, else repeat
    output reg wr_valid_o,          // Frame-memory write pixel valid
    output reg wr_sol_o,            // Write pixel starts a line
    output reg [23:0] wr_data_o,    // Write pixel data
    output reg wr_single_buf_o,     // Write into the single buffer
    output reg wr_field_o,          // Field of the written pixel
    output reg wr_dbl_valid_o,      // Interpolated in-field line valid
    output reg [23:0] wr_dbl_data_o,// Interpolated in-field line pixel
    output reg ovl_valid_o,         // Enlarged pixel to overlay valid
    output reg [23:0] ovl_data_o,   // Enlarged pixel to overlay
    output reg ovl_field_o          // Field shown by the overlay
);

// ==========================================
// Arithmetic helpers
function [7:0] f_sat;
    input integer v;
    begin
        if (v < 0) begin
            f_sat = 8'h00;
        end else if (v > 255) begin
            f_sat = 8'hff;
        end else begin
            f_sat = v[7:0];
        end
    end
endfunction

function [7:0] f_hfir;
    input [1:0] code;
    input [7:0] a, b, c, d, e;
    integer s;
    begin
        s = 0;
        case (code)
            2'h0: s = 32 * c;
            2'h1: s = 8 * b + 16 * c + 8 * d;
            2'h2: s = 6 * b + 20 * c + 6 * d;
            default: s = 3 * a + 8 * b + 10 * c + 10 * d + 3 * e;
        endcase
        f_hfir = f_sat((s + 16) >>> 5);
    end
endfunction

function [7:0] f_vfir;
    input [1:0] code;
    input [7:0] a, b, c;
    integer s;
    begin
        s = 0;
        case (code)
            2'h1: s = 4 * a + 8 * b + 4 * c;
            2'h2: s = 3 * a + 10 * b + 3 * c;
            // Code 11 is not allowed; fall back to bypass
            default: s = 16 * b;
        endcase
        f_vfir = f_sat((s + 8) >>> 4);
    end
endfunction

// Catmull-Rom cubic or bilinear between p1 and p2, phase t in 1/16
function [7:0] f_interp;
    input cub;
    input [7:0] p0, p1, p2, p3;
    input [3:0] t;
    integer a, b, c, s, r;
    begin
        a = 3 * p1 - 3 * p2 + p3 - p0;
        b = 2 * p0 - 5 * p1 + 4 * p2 - p3;
        c = p2 - p0;
        s = ((a * t + 16 * b) * t + 256 * c) * t;
        r = 8192 * p1 + s + 4096;
        if (!cub) begin
            r = 8192 * p1 + 512 * (p2 - p1) * t + 4096;
        end
        r = r >>> 13;
        f_interp = f_sat(r);
    end
endfunction

// ==========================================
// Registers and bus slave
reg [11:0] mode_reg;
reg [31:0] scale_reg;
reg [1:0] buf_reg;
reg [9:0] hlim_reg;
reg [15:0] fcnt_reg;
reg fld_reg;

wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_req & wb_we_i;
wire [17:0] hscale = {2'h0, scale_reg[15:0]};
wire [17:0] vscale = {2'h0, scale_reg[31:16]};
wire enl = (hscale < `VCS_ONE) & (vscale < `VCS_ONE);
wire red = (mode_reg[`VCS_MODE_SCL] == `VCS_SCL_REDUCE) & ~enl;
wire native_rgb_select = mode_reg[`VCS_MODE_NATIVE_RGB_SELECT];
wire [17:0] hstep = (red | enl) ? hscale : `VCS_ONE;
wire [17:0] vstep = (red | enl) ? vscale : `VCS_ONE;

always @(posedge clk_i) begin
    if (rst_i) begin
        mode_reg <= `VCS_MODE_RST;
        scale_reg <= `VCS_SCALE_RST;
        buf_reg <= `VCS_BUF_RST;
        hlim_reg <= `VCS_HLIM_RST;
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
    end else begin
        wb_ack_o <= wb_req;
        wb_dat_o <= 32'h0;
        if (wb_req && !wb_we_i) begin
            if (wb_adr_i == `VCS_ADR_MODE) begin
                wb_dat_o <= {20'h0, mode_reg};
            end else if (wb_adr_i == `VCS_ADR_SCALE) begin
                wb_dat_o <= scale_reg;
            end else if (wb_adr_i == `VCS_ADR_BUF) begin
                wb_dat_o <= {30'h0, buf_reg};
            end else if (wb_adr_i == `VCS_ADR_HLIM) begin
                wb_dat_o <= {22'h0, hlim_reg};
            end else if (wb_adr_i == `VCS_ADR_STAT) begin
                wb_dat_o <= {13'h0, fld_reg, enl, red, fcnt_reg};
            end
        end
        if (wb_wr && wb_adr_i == `VCS_ADR_MODE) begin
            if (wb_sel_i[0]) mode_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) mode_reg[11:8] <= wb_dat_i[11:8];
        end
        if (wb_wr && wb_adr_i == `VCS_ADR_SCALE) begin
            if (wb_sel_i[0]) scale_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) scale_reg[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2]) scale_reg[23:16] <= wb_dat_i[23:16];
            if (wb_sel_i[3]) scale_reg[31:24] <= wb_dat_i[31:24];
        end
        if (wb_wr && wb_adr_i == `VCS_ADR_BUF && wb_sel_i[0]) begin
            buf_reg <= wb_dat_i[1:0];
        end
        if (wb_wr && wb_adr_i == `VCS_ADR_HLIM) begin
            if (wb_sel_i[0]) hlim_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) hlim_reg[9:8] <= wb_dat_i[9:8];
        end
    end
end

// ==========================================
// Source select: capture stream, or frame-memory read when enlarging
// Both directions run through the same filters and interpolators, so a
// mode switch mid-frame corrupts the picture until the next frame.
wire src_valid = enl ? (rd_valid_i & rd_ready_o) : cap_valid_i;
wire src_sol = enl ? rd_sol_i : cap_sol_i;
wire src_sof = enl ? rd_sof_i : cap_sof_i;
wire [23:0] src_data = enl ? rd_data_i : cap_data_i;

reg [9:0] x_reg;
reg [17:0] vacc_reg;
reg [3:0] vt_reg;
reg vkeep_reg;
reg [9:0] x_next;
reg [17:0] vacc_next;
reg [17:0] vpos;
reg [3:0] vt_next;
reg vkeep_next;
reg newl_next;
wire fld_now = src_sof ? cap_field_i : fld_reg;

// Line decision is made on the first pixel of each line
always @* begin
    x_next = src_sol ? 10'h0 : x_reg + 10'h1;
    vacc_next = src_sof ? 18'h0 : vacc_reg;
    vt_next = vt_reg;
    vkeep_next = vkeep_reg;
    newl_next = src_sof ? 1'b1 : rd_new_line_o;
    vpos = 18'h0;
    if (src_valid && src_sol) begin
        if (enl) begin
            vt_next = vacc_next[10:7];
            vpos = vacc_next + vstep;
            vkeep_next = 1'b1;
            newl_next = (vpos >= `VCS_ONE);
            vacc_next = newl_next ? vpos - `VCS_ONE : vpos;
        end else begin
            vpos = src_sof ? 18'h0 : vacc_next - `VCS_ONE;
            vkeep_next = (vpos < `VCS_ONE);
            vt_next = vpos[10:7];
            vacc_next = vkeep_next ? vpos + vstep : vpos;
        end
    end
end

wire in_lim = enl | (x_next < hlim_reg);
wire fld_ok = enl | ~buf_reg[`VCS_BUF_ODD] | fld_now;
wire line_new = enl ? (src_sof | rd_new_line_o) : 1'b1;

// ==========================================
// Line buffers and vertical stage
reg [23:0] lb0 [0:1023];
reg [23:0] lb1 [0:1023];
wire [23:0] old1 = lb0[x_next];
wire [23:0] old2 = lb1[x_next];

always @(posedge clk_i) begin
    if (src_valid && line_new) begin
        lb0[x_next] <= src_data;
        lb1[x_next] <= old1;
    end
end

wire [23:0] vout;
wire [23:0] dbl;
reg [23:0] hs [0:4];
reg [23:0] w [0:3];
wire [23:0] hf;
wire [23:0] hout;
reg [3:0] ht_reg;

genvar g;
generate
    for (g = 0; g < 3; g = g + 1) begin : g_comp
        wire lum = (g == 0) | native_rgb_select;
        wire [1:0] vcode = lum ? mode_reg[`VCS_MODE_VY] : mode_reg[`VCS_MODE_VC];
        wire [1:0] hcode = lum ? mode_reg[`VCS_MODE_HY] : mode_reg[`VCS_MODE_HC];
        wire [7:0] c0 = old2[8*g+7:8*g];
        wire [7:0] c1 = old1[8*g+7:8*g];
        wire [7:0] c2 = src_data[8*g+7:8*g];
        wire [7:0] vf = f_vfir(vcode, c0, c1, c2);
        assign vout[8*g+7:8*g] = f_interp(lum, c0, vf, c2, c2, vt_next);
        assign dbl[8*g+7:8*g] = f_interp(1'b0, c1, c1, c2, c2, 4'h8);
        assign hf[8*g+7:8*g] = f_hfir(hcode, hs[0][8*g+7:8*g], hs[1][8*g+7:8*g],
            hs[2][8*g+7:8*g], hs[3][8*g+7:8*g], hs[4][8*g+7:8*g]);
        assign hout[8*g+7:8*g] = f_interp(lum, w[0][8*g+7:8*g], w[1][8*g+7:8*g],
            w[2][8*g+7:8*g], w[3][8*g+7:8*g], ht_reg);
    end
endgenerate

// ==========================================
// Horizontal stage
reg [17:0] hacc_reg;
reg par_reg;
reg hkeep_reg;
reg pend_reg;
reg first_reg;
reg emit_reg;
reg emit_sol_reg;
reg emit_fld_reg;
reg [17:0] hacc_next;
reg [17:0] hpos;
reg [3:0] ht_next;
reg par_next;
reg hkeep_next;
reg emit_next;
wire take = src_valid & in_lim & fld_ok & vkeep_next;
integer i;

always @* begin
    hacc_next = hacc_reg;
    hpos = 18'h0;
    ht_next = ht_reg;
    par_next = par_reg;
    hkeep_next = hkeep_reg;
    emit_next = 1'b0;
    if (pend_reg) begin
        // Enlarging: another output from the same window
        ht_next = hacc_reg[10:7];
        emit_next = 1'b1;
        hacc_next = hacc_reg + hstep;
    end else if (take) begin
        par_next = src_sol ? 1'b1 : ~par_reg;
        if (!red || src_sol || !par_reg) begin
            hpos = (src_sol ? `VCS_ONE : hacc_reg) - `VCS_ONE;
            emit_next = (hpos < `VCS_ONE);
            ht_next = hpos[10:7];
            hacc_next = emit_next ? hpos + hstep : hpos;
            hkeep_next = emit_next;
        end else begin
            // Second pixel of a pair follows the first
            emit_next = hkeep_reg;
        end
    end
end

wire pend_next = enl & emit_next & (hacc_next < `VCS_ONE);

always @(posedge clk_i) begin
    if (rst_i) begin
        x_reg <= 10'h0;
        vacc_reg <= 18'h0;
        vt_reg <= 4'h0;
        vkeep_reg <= 1'b1;
        fld_reg <= 1'b1;
        fcnt_reg <= 16'h0;
        hacc_reg <= `VCS_ONE;
        ht_reg <= 4'h0;
        par_reg <= 1'b0;
        hkeep_reg <= 1'b0;
        pend_reg <= 1'b0;
        first_reg <= 1'b0;
        emit_reg <= 1'b0;
        emit_sol_reg <= 1'b0;
        emit_fld_reg <= 1'b0;
        rd_ready_o <= 1'b0;
        rd_new_line_o <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            hs[i] <= 24'h0;
        end
        for (i = 0; i < 4; i = i + 1) begin
            w[i] <= 24'h0;
        end
    end else begin
        if (src_valid) begin
            x_reg <= x_next;
            vacc_reg <= vacc_next;
            vt_reg <= vt_next;
            vkeep_reg <= vkeep_next;
            fld_reg <= fld_now;
            rd_new_line_o <= newl_next;
        end
        // One field count per captured field, tracked by the overlay
        if (!enl && cap_valid_i && cap_sof_i && fld_ok) begin
            fcnt_reg <= fcnt_reg + 16'h1;
        end
        hacc_reg <= hacc_next;
        ht_reg <= ht_next;
        par_reg <= par_next;
        hkeep_reg <= hkeep_next;
        pend_reg <= pend_next;
        rd_ready_o <= ~pend_next;
        if (take && !pend_reg) begin
            hs[4] <= hs[3];
            hs[3] <= hs[2];
            hs[2] <= hs[1];
            hs[1] <= hs[0];
            hs[0] <= vout;
            w[3] <= hf;
            w[2] <= w[3];
            w[1] <= w[2];
            w[0] <= w[1];
        end
        if (take && src_sol) begin
            first_reg <= 1'b1;
        end else if (emit_next) begin
            first_reg <= 1'b0;
        end
        emit_reg <= emit_next;
        emit_sol_reg <= emit_next & (first_reg | (take & src_sol));
        emit_fld_reg <= fld_now;
    end
end

// ==========================================
// Outputs toward frame memory and overlay
// The interpolator reads the window one cycle after the decision
always @(posedge clk_i) begin
    if (rst_i) begin
        wr_valid_o <= 1'b0;
        wr_sol_o <= 1'b0;
        wr_data_o <= 24'h0;
        wr_single_buf_o <= 1'b0;
        wr_field_o <= 1'b0;
        wr_dbl_valid_o <= 1'b0;
        wr_dbl_data_o <= 24'h0;
        ovl_valid_o <= 1'b0;
        ovl_data_o <= 24'h0;
        ovl_field_o <= 1'b0;
    end else begin
        wr_valid_o <= emit_reg & ~enl;
        wr_sol_o <= emit_sol_reg & ~enl;
        wr_field_o <= emit_fld_reg;
        wr_single_buf_o <= buf_reg[`VCS_BUF_555];
        if (buf_reg[`VCS_BUF_555]) begin
            // Low three bits of each component are dropped
            wr_data_o <= {9'h0, hout[23:19], hout[15:11], hout[7:3]};
        end else begin
            wr_data_o <= hout;
        end
        // In-field doubling is offered only at unity scale
        wr_dbl_valid_o <= take & ~enl & ~red & ~mode_reg[`VCS_MODE_VI];
        wr_dbl_data_o <= dbl;
        ovl_valid_o <= emit_reg & enl;
        ovl_data_o <= hout;
        if (!enl && cap_valid_i && cap_sof_i && fld_ok) begin
            ovl_field_o <= fld_now;
        end
    end
end

endmodule
`default_nettype wire

// file: verification/vcs_scaler_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Port checks
module vcs_scaler_sva (
    input wire clk_i, // Clock
    input wire rst_i, // Reset
    input wire wb_cyc_i, // Cycle
    input wire wb_stb_i, // Strobe
    input wire wb_we_i, // Write
    input wire [7:0] wb_adr_i, // Address
    input wire [31:0] wb_dat_o, // Read data
    input wire wb_ack_o, // Ack
    input wire cap_valid_i, // Pixel in
    input wire rd_ready_o, // Read ready
    input wire rd_new_line_o, // Fresh line
    input wire wr_valid_o, // Pixel out
    input wire [23:0] wr_data_o, // Pixel data
    input wire wr_single_buf_o, // Single buffer
    input wire wr_dbl_valid_o // Doubled line
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    a_hole_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h14
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_wr_lag: assert property (wr_valid_o |-> $past(cap_valid_i, 2))
        else $error("written pixel without input");
    a_dbl_lag: assert property (wr_dbl_valid_o |-> $past(cap_valid_i))
        else $error("doubled pixel without input");
    a_555_width: assert property (wr_valid_o && wr_single_buf_o |-> wr_data_o[23:15] == 9'h0)
        else $error("single buffer pixel too wide");
    // Reset itself is the antecedent here, so the default disable is overridden
    a_reset_out: assert property (disable iff (1'b0) rst_i |=> !wr_valid_o &&
        !wr_dbl_valid_o && !rd_ready_o && rd_new_line_o && !wb_ack_o)
        else $error("outputs not at reset level");
    c_single: cover property (wr_valid_o && wr_single_buf_o);
    c_dbl: cover property (wr_dbl_valid_o);
    c_read: cover property (wb_ack_o && !$past(wb_we_i));
endmodule
bind vcs_video_capture_scaler vcs_scaler_sva u_vcs_scaler_sva (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .cap_valid_i(cap_valid_i),
    .rd_ready_o(rd_ready_o),
    .rd_new_line_o(rd_new_line_o),
    .wr_valid_o(wr_valid_o),
    .wr_data_o(wr_data_o),
    .wr_single_buf_o(wr_single_buf_o),
    .wr_dbl_valid_o(wr_dbl_valid_o)
);
`default_nettype wire

// file: verification/vcs_video_capture_scaler_test.sv
`timescale 1ns/100ps
`default_nettype none
module vcs_video_capture_scaler_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, sof = 1'b0, fld = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, d;
    logic [9:0] npix = 10'h000;
    logic [23:0] pix = 24'h0, exp_data = 24'h0;
    logic [31:0] wb_dat_o;
    logic [23:0] cap_data, wr_data_o;
    logic wb_ack_o, cap_valid, cap_sol, cap_sof, cap_field, wr_valid_o, wr_dbl_valid_o;
    logic ovl_field_o, wr_field_o, wr_single_buf_o, rd_ready_o;
    logic [23:0] wr_dbl_data_o;
    logic [1:0] exp_fs = 2'h0;
    logic arm = 1'b0;
    logic [7:0] adrs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
    logic [31:0] rsts [5] = '{32'h0, 32'h08000800, 32'h0, 32'h348, 32'h0};
    int errors = 0, n_compared = 0, n_wr = 0, n_dbl = 0;
    always #5 clk_i = ~clk_i;
    vcs_video_source u_vcs_video_source (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
        .sof_i(sof), .field_i(fld), .npix_i(npix), .pix_i(pix), .cap_valid_o(cap_valid),
        .cap_sol_o(cap_sol), .cap_sof_o(cap_sof), .cap_field_o(cap_field),
        .cap_data_o(cap_data));
    vcs_video_capture_scaler u_vcs_video_capture_scaler (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cap_valid_i(cap_valid),
        .cap_sol_i(cap_sol), .cap_sof_i(cap_sof), .cap_field_i(cap_field),
        .cap_data_i(cap_data), .rd_valid_i(1'b0), .rd_sol_i(1'b0), .rd_sof_i(1'b0),
        .rd_data_i(24'h0), .rd_ready_o(rd_ready_o), .rd_new_line_o(), .wr_valid_o(wr_valid_o),
        .wr_sol_o(), .wr_data_o(wr_data_o), .wr_single_buf_o(wr_single_buf_o),
        .wr_field_o(wr_field_o), .wr_dbl_valid_o(wr_dbl_valid_o),
        .wr_dbl_data_o(wr_dbl_data_o), .ovl_valid_o(), .ovl_data_o(),
        .ovl_field_o(ovl_field_o));
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task stop_test;
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ==========================================
    // Bus access and output monitor
    task wb(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        r = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    // Line buffers and filter windows start empty, so data is compared once primed
    always @(posedge clk_i) begin
        if (wr_valid_o === 1'b1) begin
            n_wr++;
            if (arm) begin
                check({8'h0, wr_data_o}, {8'h0, exp_data});
                check({30'h0, wr_field_o, wr_single_buf_o}, {30'h0, exp_fs});
            end
        end
        if (wr_dbl_valid_o === 1'b1) begin
            n_dbl++;
            if (arm) check({8'h0, wr_dbl_data_o}, {8'h0, exp_data});
        end
    end
    // Constant pixels keep every interpolator and every filter except horizontal code 3 (taps sum to 34) at the input value
    task run(input logic [31:0] mode, scale, bm, hlim, input int lines, np,
        input logic f, input logic [23:0] p, input int ew, ed, input logic [23:0] ex);
        wb(1'b1, 8'h00, mode, d);
        wb(1'b1, 8'h04, scale, d);
        wb(1'b1, 8'h08, bm, d);
        wb(1'b1, 8'h0c, hlim, d);
        exp_data = ex;
        exp_fs = {f, bm[1]};
        n_wr = 0;
        n_dbl = 0;
        for (int l = 0; l < lines; l++) begin
            go <= 1'b1;
            sof <= (l == 0);
            fld <= f;
            npix <= np[9:0];
            pix <= p;
            @(posedge clk_i);
            go <= 1'b0;
            // Drain margin covers the filter window lag behind the last pixel
            repeat (np + 16) @(posedge clk_i);
        end
        check(n_wr, ew);
        check(n_dbl, ed);
        if (ew > 0) check({31'h0, ovl_field_o}, {31'h0, f});
    endtask
    // ==========================================
    // Test sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, adrs[i], 32'h0, d);
            check(d, rsts[i]);
        end
        wb(1'b1, 8'h04, 32'h096808e3, d);
        wb(1'b0, 8'h04, 32'h0, d);
        check(d, 32'h096808e3);
        wb(1'b1, 8'h14, 32'hffffffff, d);
        wb(1'b0, 8'h14, 32'h0, d);
        check(d, 32'h0);
        // Three lines fill both line buffers and the filter windows with one value
        run(32'h004, 32'h08000800, 0, 32'h348, 3, 16, 1, 24'ha5c3f7, 48, 0, 24'ha5c3f7);
        arm = 1'b1;
        run(32'h004, 32'h08000800, 0, 32'h348, 1, 16, 1, 24'ha5c3f7, 16, 0, 24'ha5c3f7);
        run(32'h000, 32'h08000800, 0, 32'h348, 1, 16, 1, 24'ha5c3f7, 16, 16, 24'ha5c3f7);
        run(32'h004, 32'h08000800, 0, 32'h008, 1, 16, 1, 24'ha5c3f7, 8, 0, 24'ha5c3f7);
        run(32'h004, 32'h08000800, 1, 32'h348, 2, 16, 0, 24'ha5c3f7, 0, 0, 24'ha5c3f7);
        run(32'h004, 32'h08000800, 1, 32'h348, 1, 16, 1, 24'ha5c3f7, 16, 0, 24'ha5c3f7);
        run(32'h004, 32'h08000800, 2, 32'h348, 1, 16, 1, 24'ha5c3f7, 16, 0, 24'h00531e);
        run(32'h997, 32'h08001000, 0, 32'h348, 1, 16, 1, 24'ha5c3f7, 8, 0, 24'ha5c3f7);
        run(32'h004, 32'h08001000, 0, 32'h348, 1, 16, 1, 24'ha5c3f7, 16, 0, 24'ha5c3f7);
        run(32'h007, 32'h10000800, 0, 32'h348, 2, 16, 1, 24'ha5c3f7, 16, 0, 24'ha5c3f7);
        run(32'h0cc, 32'h08000800, 0, 32'h348, 1, 16, 1, 24'ha5c3f7, 16, 0, 24'ha5c3f7);
        wb(1'b0, 8'h10, 32'h0, d);
        check(d, 32'h0004000a);
        wb(1'b1, 8'h04, 32'h06000600, d);
        wb(1'b0, 8'h10, 32'h0, d);
        check(d, 32'h0006000a);
        check({31'h0, rd_ready_o}, 32'h1);
        stop_test;
    end
    initial begin
        #200000;
        errors++;
        stop_test;
    end
endmodule
`default_nettype wire

// file: verification/vcs_video_source.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Capture source: one line of pixels per go pulse
module vcs_video_source (
    input wire logic clk_i, // Clock
    input wire logic rst_i, // Reset
    input wire logic go_i, // Start a line
    input wire logic sof_i, // Line opens a field
    input wire logic field_i, // Field, 1 = odd
    input wire logic [9:0] npix_i, // Pixels in line
    input wire logic [23:0] pix_i, // Pixel value
    output logic cap_valid_o, // Pixel strobe
    output logic cap_sol_o, // First of line
    output logic cap_sof_o, // First of field
    output logic cap_field_o, // Field tag
    output logic [23:0] cap_data_o // Pixel data
);
    logic [9:0] cnt_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= 10'h000;
            cap_valid_o <= 1'b0;
            cap_sol_o <= 1'b0;
            cap_sof_o <= 1'b0;
            cap_field_o <= 1'b0;
            cap_data_o <= 24'h000000;
        end else if (go_i || cnt_reg != 10'h000) begin
            cap_valid_o <= 1'b1;
            cap_sol_o <= go_i;
            cap_sof_o <= go_i & sof_i;
            cap_field_o <= field_i;
            cap_data_o <= pix_i;
            cnt_reg <= go_i ? npix_i - 10'h001 : cnt_reg - 10'h001;
        end else begin
            cap_valid_o <= 1'b0;
            cap_sol_o <= 1'b0;
            cap_sof_o <= 1'b0;
            // Idle data toggles so a stale pixel can never pass for a fresh one
            cap_data_o <= ~cap_data_o;
        end
    end
endmodule
`default_nettype wire
